// >>> src/flash_security_lockout_map.vh
// constants for the flash security interlock and its test access port
// assumes a single system clock and a tap driven from pins
`ifndef FLASH_SECURITY_LOCKOUT_MAP_VH
`define FLASH_SECURITY_LOCKOUT_MAP_VH

// security word location and codes
`define SEC_WORD_ADDR      16'h7FF7
`define SEC_CODE_SECURED   16'h0002
`define SEC_CODE_OPEN      16'h0000

// tap instruction register
`define IR_W               4
`define IR_CAPTURE         4'h1
`define IR_EXTEST          4'h0
`define IR_IDCODE          4'h2
`define IR_DEBUG           4'h7
`define IR_LOCKOUT         4'h8
`define IR_BYPASS          4'hF

// data register widths, debug command field and codes
`define ERASE_DIV_W        7
`define DBG_DR_W           18
`define DBG_CMD_LSB        16
`define DBG_CMD_FLASH_RD   2'h1
`define DBG_CMD_CORE       2'h2

`endif

// >>> src/flash_security_lockout.v
// flash security interlock: security flag, chip tap, debug gate, lockout erase
// assumes tck/tms/tdi are pins slower than clk; flash engine does the erase
//
// Summary of operation
// - securing code in word secures device persistently
// - secured: debug disabled, execution unchanged
// - debug port mapped onto four jtag pins
// - chip tap always active: boundary scan, id
// - secured: reject debug flash accesses
// - recovery mass-erases flash and protection register
// - unsecure only at next reset after erase
// - seven-bit divider register under that instruction
// - erase starts on entering run-test/idle from update-dr
// - power-on reset resets tap and device
// - all-zero word unsecures after reset
// - programming only clears bits to zero
// - resolve security between peripheral and core reset
// - tap resets on five tms-high tck edges
`timescale 1ns/1ps
`default_nettype none
`include "flash_security_lockout_map.vh"

module flash_security_lockout #(
    parameter [31:0] ID_CODE = 32'h0000_1001, // arbitrary value
    parameter        BSR_W   = 8              // boundary scan cells
) (
    // clock and reset
    input  wire              clk,
    input  wire              rst_n,
    // reset phases from the system
    input  wire              perip_rst_n,
    input  wire              core_rst_n,
    // security word as read from the flash_array
    input  wire [15:0]       sec_word,
    // jtag pins
    input  wire              tck,
    input  wire              tms,
    input  wire              tdi,
    output reg               tdo_r,
    output reg               tdo_oe_r,
    // boundary scan
    input  wire [BSR_W-1:0]  bs_pin_in,
    output reg  [BSR_W-1:0]  bs_pin_out_r,
    output reg               bs_extest_r,
    // security state
    output reg               secure_r,
    output reg               sec_valid_r,
    output reg               dbg_enable_r,
    // debug requests toward the core
    input  wire [15:0]       dbg_rdata,
    output reg               dbg_req_r,
    output reg  [1:0]        dbg_cmd_r,
    output reg  [15:0]       dbg_addr_r,
    output reg               dbg_reject_r,
    // mass erase engine
    input  wire              erase_done,
    output reg               erase_start_r,
    output reg  [`ERASE_DIV_W-1:0] erase_div_r,
    output reg               erase_busy_r,
    output reg               erase_complete_r,
    output reg               prot_clear_r
);

    //--------------------------------------------------------------
    // tap states
    //--------------------------------------------------------------
    localparam [3:0] S_TLR  = 4'h0;
    localparam [3:0] S_RTI  = 4'h1;
    localparam [3:0] S_SDR  = 4'h2;
    localparam [3:0] S_CDR  = 4'h3;
    localparam [3:0] S_SHDR = 4'h4;
    localparam [3:0] S_E1DR = 4'h5;
    localparam [3:0] S_PDR  = 4'h6;
    localparam [3:0] S_E2DR = 4'h7;
    localparam [3:0] S_UDR  = 4'h8;
    localparam [3:0] S_SIR  = 4'h9;
    localparam [3:0] S_CIR  = 4'hA;
    localparam [3:0] S_SHIR = 4'hB;
    localparam [3:0] S_E1IR = 4'hC;
    localparam [3:0] S_PIR  = 4'hD;
    localparam [3:0] S_E2IR = 4'hE;
    localparam [3:0] S_UIR  = 4'hF;

    //--------------------------------------------------------------
    // pin synchronisers
    //--------------------------------------------------------------
    reg  [2:0]              tck_sync_r;   // two sync stages plus history
    reg  [1:0]              tms_sync_r;   // two sync stages
    reg  [1:0]              tdi_sync_r;   // two sync stages
    reg  [1:0]              prst_sync_r;  // peripheral reset sync
    reg  [1:0]              crst_sync_r;  // core reset sync
    reg  [2*BSR_W-1:0]      bs_sync_r;    // boundary pins, two stages
    wire                    tck_rise;     // tck rising edge seen
    wire                    tck_fall;     // tck falling edge seen
    wire                    tms_s;
    wire                    tdi_s;

    // pins pass two flops before use; edge detect reads stage 2 and 3
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tck_sync_r  <= 3'h0;
            tms_sync_r  <= 2'h3;
            tdi_sync_r  <= 2'h3;
            prst_sync_r <= 2'h0;
            crst_sync_r <= 2'h0;
            bs_sync_r   <= {2*BSR_W{1'b0}};
        end else begin
            tck_sync_r  <= {tck_sync_r[1:0], tck};
            tms_sync_r  <= {tms_sync_r[0], tms};
            tdi_sync_r  <= {tdi_sync_r[0], tdi};
            prst_sync_r <= {prst_sync_r[0], perip_rst_n};
            crst_sync_r <= {crst_sync_r[0], core_rst_n};
            bs_sync_r   <= {bs_sync_r[BSR_W-1:0], bs_pin_in};
        end
    end

    assign tck_rise = tck_sync_r[1] & ~tck_sync_r[2];
    assign tck_fall = ~tck_sync_r[1] & tck_sync_r[2];
    assign tms_s    = tms_sync_r[1];
    assign tdi_s    = tdi_sync_r[1];

    //--------------------------------------------------------------
    // security flag
    //--------------------------------------------------------------
    // sampled while peripherals run and core is held; frozen until reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            secure_r     <= 1'b1;   // assume secured until resolved
            sec_valid_r  <= 1'b0;
            dbg_enable_r <= 1'b0;
        end else if (prst_sync_r[1] && !crst_sync_r[1]) begin
            // only the exact securing code secures; 0000 or erased opens
            secure_r     <= (sec_word == `SEC_CODE_SECURED);
            sec_valid_r  <= 1'b1;
            dbg_enable_r <= 1'b0;   // debug stays off until core runs
        end else if (crst_sync_r[1] && sec_valid_r) begin
            dbg_enable_r <= ~secure_r;
        end
    end

    //--------------------------------------------------------------
    // tap state machine, stepped on synced tck rising edges
    //--------------------------------------------------------------
    reg  [3:0]              tap_st_r;
    reg  [3:0]              tap_nxt;

    // standard next state; five tms-high edges always reach reset
    always @* begin
        case (tap_st_r)
            S_TLR:   tap_nxt = tms_s ? S_TLR  : S_RTI;
            S_RTI:   tap_nxt = tms_s ? S_SDR  : S_RTI;
            S_SDR:   tap_nxt = tms_s ? S_SIR  : S_CDR;
            S_CDR:   tap_nxt = tms_s ? S_E1DR : S_SHDR;
            S_SHDR:  tap_nxt = tms_s ? S_E1DR : S_SHDR;
            S_E1DR:  tap_nxt = tms_s ? S_UDR  : S_PDR;
            S_PDR:   tap_nxt = tms_s ? S_E2DR : S_PDR;
            S_E2DR:  tap_nxt = tms_s ? S_UDR  : S_SHDR;
            S_UDR:   tap_nxt = tms_s ? S_SDR  : S_RTI;
            S_SIR:   tap_nxt = tms_s ? S_TLR  : S_CIR;
            S_CIR:   tap_nxt = tms_s ? S_E1IR : S_SHIR;
            S_SHIR:  tap_nxt = tms_s ? S_E1IR : S_SHIR;
            S_E1IR:  tap_nxt = tms_s ? S_UIR  : S_PIR;
            S_PIR:   tap_nxt = tms_s ? S_E2IR : S_PIR;
            S_E2IR:  tap_nxt = tms_s ? S_UIR  : S_SHIR;
            S_UIR:   tap_nxt = tms_s ? S_SDR  : S_RTI;
            default: tap_nxt = S_TLR;
        endcase
    end

    // power-on reset puts the tap in test-logic-reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tap_st_r <= S_TLR;
        end else if (tck_rise) begin
            tap_st_r <= tap_nxt;
        end
    end

    //--------------------------------------------------------------
    // instruction and data registers
    //--------------------------------------------------------------
    reg  [`IR_W-1:0]        ir_sh_r;      // instruction shifter
    reg  [`IR_W-1:0]        ir_r;         // active instruction
    reg  [31:0]             id_sh_r;      // id code shifter
    reg                     byp_r;        // bypass cell
    reg  [BSR_W-1:0]        bsr_sh_r;     // boundary scan shifter
    reg  [`ERASE_DIV_W-1:0] div_sh_r;     // erase divider shifter
    reg  [`DBG_DR_W-1:0]    dbg_sh_r;     // debug command shifter
    reg                     lock_armed_r; // divider shifted under lockout
    wire                    dr_sel_out;   // serial out of selected dr

    // ir active from boot; reset selects id access
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_sh_r <= `IR_CAPTURE;
            ir_r    <= `IR_IDCODE;
        end else if (tck_rise) begin
            case (tap_st_r)
                S_TLR:   ir_r    <= `IR_IDCODE;
                S_CIR:   ir_sh_r <= `IR_CAPTURE;
                S_SHIR:  ir_sh_r <= {tdi_s, ir_sh_r[`IR_W-1:1]};
                S_UIR:   ir_r    <= ir_sh_r;
                default: ir_sh_r <= ir_sh_r;
            endcase
        end
    end

    // data registers: capture, shift lsb first, update
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            id_sh_r      <= 32'h0000_0000;
            byp_r        <= 1'b0;
            bsr_sh_r     <= {BSR_W{1'b0}};
            div_sh_r     <= {`ERASE_DIV_W{1'b0}};
            dbg_sh_r     <= {`DBG_DR_W{1'b0}};
            bs_pin_out_r <= {BSR_W{1'b0}};
            bs_extest_r  <= 1'b0;
            lock_armed_r <= 1'b0;
            erase_div_r  <= {`ERASE_DIV_W{1'b0}};
        end else if (tck_rise) begin
            bs_extest_r <= (ir_r == `IR_EXTEST);
            case (tap_st_r)
                S_TLR: begin
                    lock_armed_r <= 1'b0;
                end
                S_CDR: begin
                    id_sh_r  <= ID_CODE;
                    byp_r    <= 1'b0;
                    bsr_sh_r <= bs_sync_r[2*BSR_W-1:BSR_W];
                    dbg_sh_r <= {2'h0, dbg_rdata};
                end
                S_SHDR: begin
                    case (ir_r)
                        `IR_IDCODE:  id_sh_r  <= {tdi_s, id_sh_r[31:1]};
                        `IR_EXTEST:  bsr_sh_r <= {tdi_s, bsr_sh_r[BSR_W-1:1]};
                        `IR_LOCKOUT: begin
                            div_sh_r     <= {tdi_s, div_sh_r[`ERASE_DIV_W-1:1]};
                            lock_armed_r <= 1'b1;   // divider shifted
                        end
                        `IR_DEBUG:   dbg_sh_r <= {tdi_s, dbg_sh_r[`DBG_DR_W-1:1]};
                        default:     byp_r    <= tdi_s;
                    endcase
                end
                S_UDR: begin
                    if (ir_r == `IR_EXTEST) begin
                        bs_pin_out_r <= bsr_sh_r;
                    end
                    if (ir_r == `IR_LOCKOUT) begin
                        erase_div_r  <= div_sh_r;
                    end
                end
                S_RTI: begin
                    lock_armed_r <= 1'b0;   // consumed on idle entry
                end
                default: begin
                    if (ir_r != `IR_LOCKOUT) begin // other instruction: unarmed
                        lock_armed_r <= 1'b0;
                    end
                end
            endcase
        end
    end

    // selected data register serial output
    assign dr_sel_out = (ir_r == `IR_IDCODE)  ? id_sh_r[0]  :
                        (ir_r == `IR_EXTEST)  ? bsr_sh_r[0] :
                        (ir_r == `IR_LOCKOUT) ? div_sh_r[0] :
                        (ir_r == `IR_DEBUG)   ? dbg_sh_r[0] : byp_r;

    // tdo changes on the falling tck edge, driven only while shifting
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tdo_r    <= 1'b0;
            tdo_oe_r <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_r <= (tap_st_r == S_SHDR) || (tap_st_r == S_SHIR);
            tdo_r    <= (tap_st_r == S_SHIR) ? ir_sh_r[0] : dr_sel_out;
        end
    end

    //--------------------------------------------------------------
    // debug port gate
    //--------------------------------------------------------------
    // one request per debug update; refused unless debug is enabled
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dbg_req_r    <= 1'b0;
            dbg_cmd_r    <= 2'h0;
            dbg_addr_r   <= 16'h0000;
            dbg_reject_r <= 1'b0;
        end else begin
            dbg_req_r    <= 1'b0;
            dbg_reject_r <= 1'b0;
            if (tck_rise && tap_st_r == S_UDR && ir_r == `IR_DEBUG) begin
                if (dbg_enable_r) begin
                    dbg_req_r  <= 1'b1;
                    dbg_cmd_r  <= dbg_sh_r[`DBG_DR_W-1:`DBG_CMD_LSB];
                    dbg_addr_r <= dbg_sh_r[15:0];
                end else begin
                    dbg_reject_r <= 1'b1;
                end
            end
        end
    end

    //--------------------------------------------------------------
    // lockout erase sequencer
    //--------------------------------------------------------------
    // start on update-dr to idle after a divider shift under lockout; the
    // engine erases array, config field and protection; secure_r stays
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            erase_start_r    <= 1'b0;
            erase_busy_r     <= 1'b0;
            erase_complete_r <= 1'b0;
            prot_clear_r     <= 1'b0;
        end else begin
            erase_start_r <= 1'b0;
            prot_clear_r  <= 1'b0;
            if (tck_rise && tap_nxt == S_RTI && tap_st_r == S_UDR
                && lock_armed_r && !erase_busy_r) begin
                erase_start_r    <= 1'b1;
                erase_busy_r     <= 1'b1;
                erase_complete_r <= 1'b0;
            end else if (erase_busy_r && erase_done) begin
                // host keeps tap idle until here; flag stays until reset or the next erase start
                erase_busy_r     <= 1'b0;
                erase_complete_r <= 1'b1;
                prot_clear_r     <= 1'b1;
            end
        end
    end

endmodule // flash_security_lockout
`default_nettype wire

// >>> dv/flash_security_lockout_properties.sv
// checker for the flash security interlock: erase engine, debug gate, flag
// assumes one clk domain and an async active-low rst_n
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// port-level properties
// ----------------------------------------
module flash_security_lockout_properties (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // erase engine
    input wire logic erase_done,
    input wire logic erase_start_r,
    input wire logic erase_busy_r,
    input wire logic erase_complete_r,
    input wire logic prot_clear_r,
    // security and debug
    input wire logic secure_r,
    input wire logic sec_valid_r,
    input wire logic dbg_enable_r,
    input wire logic dbg_req_r,
    input wire logic dbg_reject_r
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_start_busy: assert property (erase_start_r |-> erase_busy_r ##1 !erase_start_r)
        else $error("erase start without busy");
    chk_busy_origin: assert property ($rose(erase_busy_r) |-> erase_start_r)
        else $error("busy rose without start");
    chk_done_ends: assert property (erase_busy_r && erase_done && !erase_start_r
        |=> !erase_busy_r && erase_complete_r) else $error("done did not end erase");
    chk_complete_prot: assert property ($rose(erase_complete_r) |-> prot_clear_r)
        else $error("completion without protection clear");
    chk_prot_pulse: assert property (prot_clear_r |=> !prot_clear_r)
        else $error("protection clear not a pulse");
    chk_complete_sticky: assert property (erase_complete_r |=> erase_complete_r)
        else $error("completion flag dropped");
    chk_flag_frozen: assert property (sec_valid_r && $past(sec_valid_r) |-> $stable(secure_r))
        else $error("secure flag moved after resolution");
    chk_debug_gate: assert property (dbg_enable_r |-> !secure_r && sec_valid_r)
        else $error("debug enabled while secured");
    chk_secure_noreq: assert property (secure_r |-> !dbg_req_r)
        else $error("debug request passed while secured");
    chk_req_pulse: assert property (dbg_req_r |-> !dbg_reject_r ##1 !dbg_req_r)
        else $error("request pulse malformed");
    chk_reject_cause: assert property (dbg_reject_r |-> !dbg_enable_r)
        else $error("reject while debug enabled");

    cov_erase: cover property (erase_start_r);
    cov_reject: cover property (dbg_reject_r);
    cov_accept: cover property (dbg_req_r);
endmodule // flash_security_lockout_properties

bind flash_security_lockout flash_security_lockout_properties u_props (
    .clk(clk), .rst_n(rst_n), .erase_done(erase_done), .erase_start_r(erase_start_r),
    .erase_busy_r(erase_busy_r), .erase_complete_r(erase_complete_r),
    .prot_clear_r(prot_clear_r), .secure_r(secure_r), .sec_valid_r(sec_valid_r),
    .dbg_enable_r(dbg_enable_r), .dbg_req_r(dbg_req_r), .dbg_reject_r(dbg_reject_r));
`default_nettype wire

// >>> dv/jtag_host.sv
// external jtag host model driving the chip tap pins
// assumes clk is the system clock; tck stands low between frames
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// host tasks
// ----------------------------------------
module jtag_host (
    // system clock and tap answer
    input  wire logic clk,
    input  wire logic tdo_r,
    // tap pins
    output var  logic tck,
    output var  logic tms,
    output var  logic tdi
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one tck period, six clk low and five clk high; tdo taken before the rise
    task automatic step(input logic m, input logic d, output logic o);
        @(posedge clk);
        tms <= m;
        tdi <= d;
        repeat (5) @(posedge clk);
        o = tdo_r;
        tck <= 1'b1;
        repeat (5) @(posedge clk);
        tck <= 1'b0;
    endtask

    // five tms-high edges, then idle
    task automatic tap_reset();
        logic o;
        repeat (5) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask

    // load instruction from idle, back to idle via update-ir
    task automatic load_ir(input logic [3:0] code);
        logic o;
        step(1'b1, 1'b0, o);
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < 4; i++) step(i == 3, code[i], o);
        step(1'b1, 1'b0, o);
        step(1'b0, ~code[3], o); // released data line flips
    endtask

    // scan n bits lsb first, update, then straight into idle
    task automatic scan_dr(input logic [31:0] d, input int n, output logic [31:0] q);
        logic o;
        q = 32'h0;
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, d[i], o);
            q[i] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, ~d[n-1], o); // idle held, tck still
    endtask
endmodule // jtag_host
`default_nettype wire

// >>> dv/tb_flash_security_lockout.sv
// self-checking bench for the flash security interlock
// assumes jtag_host model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "flash_security_lockout_map.vh"

// ----------------------------------------
// bench top
// ----------------------------------------
module tb_flash_security_lockout;
    logic        clk, rst_n, perip_rst_n, core_rst_n, erase_done;
    logic        tck, tms, tdi, tdo_r, secure_r, sec_valid_r, dbg_enable_r;
    logic        dbg_req_r, dbg_reject_r, erase_start_r, erase_busy_r;
    logic        erase_complete_r, prot_clear_r, tdo_oe_r, bs_extest_r;
    logic [7:0]  bs_pin_out_r;
    logic [15:0] sec_word, dbg_addr_r;
    logic [1:0]  dbg_cmd_r;
    logic [6:0]  erase_div_r;
    logic [31:0] q;
    int          fails, tests_run, cycles, n_req, n_rej, n_start, n_prot, n_oe;

    flash_security_lockout #(.ID_CODE(32'h0000_1001), .BSR_W(8)) dut (
        .clk(clk), .rst_n(rst_n), .perip_rst_n(perip_rst_n), .core_rst_n(core_rst_n),
        .sec_word(sec_word), .tck(tck), .tms(tms), .tdi(tdi), .tdo_r(tdo_r),
        .tdo_oe_r(tdo_oe_r), .bs_pin_in(8'hA5), .bs_pin_out_r(bs_pin_out_r),
        .bs_extest_r(bs_extest_r), .secure_r(secure_r), .sec_valid_r(sec_valid_r),
        .dbg_enable_r(dbg_enable_r),
        .dbg_rdata(16'h1234), .dbg_req_r(dbg_req_r), .dbg_cmd_r(dbg_cmd_r),
        .dbg_addr_r(dbg_addr_r), .dbg_reject_r(dbg_reject_r), .erase_done(erase_done),
        .erase_start_r(erase_start_r), .erase_div_r(erase_div_r),
        .erase_busy_r(erase_busy_r), .erase_complete_r(erase_complete_r),
        .prot_clear_r(prot_clear_r));

    jtag_host host (.clk(clk), .tdo_r(tdo_r), .tck(tck), .tms(tms), .tdi(tdi));

    // clock and pulse counters
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        n_req += dbg_req_r;
        n_rej += dbg_reject_r;
        n_start += erase_start_r;
        n_prot += prot_clear_r;
        n_oe += tdo_oe_r;
        cycles++;
        if (cycles == 60000) begin
            fails++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // phased reset: peripheral release, then core 32 clk later
    task automatic do_reset(input logic [15:0] word);
        @(posedge clk);
        rst_n <= 1'b0;
        perip_rst_n <= 1'b0;
        core_rst_n <= 1'b0;
        sec_word <= word;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        perip_rst_n <= 1'b1;
        repeat (32) @(posedge clk);
        core_rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        {n_req, n_rej, n_start, n_prot, n_oe} = '0;
    endtask

    // secured boot, id still readable, debug refused
    task automatic t_secured();
        do_reset(`SEC_CODE_SECURED);
        check(secure_r, 1'b1);
        check(sec_valid_r, 1'b1);
        check(dbg_enable_r, 1'b0);
        host.tap_reset();
        host.load_ir(`IR_IDCODE);
        host.scan_dr(32'h0, 32, q);
        check(q, 32'h0000_1001);
        check(n_oe != 0, 1'b1);
        check(tdo_oe_r, 1'b0);
        host.load_ir(`IR_EXTEST);
        host.scan_dr(32'h3C, 8, q);
        check(q, 32'h0000_00A5);
        check(bs_pin_out_r, 8'h3C);
        check(bs_extest_r, 1'b1);
        host.load_ir(`IR_DEBUG);
        host.scan_dr({14'h0, `DBG_CMD_FLASH_RD, `SEC_WORD_ADDR}, 18, q);
        check(n_rej, 1);
        check(n_req, 0);
        $display("test secured done");
    endtask

    // lockout recovery: refused via update-ir, then full sequence
    task automatic t_lockout();
        host.load_ir(`IR_LOCKOUT);
        check(n_start, 0);
        host.scan_dr(32'h55, 7, q);
        for (int k = 0; k < 50 && erase_busy_r !== 1'b1; k++) @(posedge clk);
        check(n_start, 1);
        check(erase_div_r, 7'h55);
        repeat (40) @(posedge clk);
        erase_done <= 1'b1;
        for (int k = 0; k < 50 && erase_complete_r !== 1'b1; k++) @(posedge clk);
        erase_done <= 1'b0;
        repeat (2) @(posedge clk);
        check(erase_busy_r, 1'b0);
        check(n_prot, 1);
        check(secure_r, 1'b1);
        host.tap_reset();
        do_reset(16'hFFFF);
        check(secure_r, 1'b0);
        $display("test lockout done");
    endtask

    // zero word unsecures; debug read accepted; flag frozen
    task automatic t_open();
        do_reset(`SEC_CODE_OPEN);
        check(secure_r, 1'b0);
        check(dbg_enable_r, 1'b1);
        host.tap_reset();
        host.load_ir(`IR_DEBUG);
        host.scan_dr({14'h0, `DBG_CMD_FLASH_RD, `SEC_WORD_ADDR}, 18, q);
        check(n_req, 1);
        check(q, 32'h0000_1234);
        check(dbg_cmd_r, `DBG_CMD_FLASH_RD);
        check(dbg_addr_r, `SEC_WORD_ADDR);
        sec_word <= `SEC_CODE_SECURED;
        repeat (40) @(posedge clk);
        check(secure_r, 1'b0);
        $display("test open done");
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // main sequence
    initial begin
        {rst_n, perip_rst_n, core_rst_n, erase_done} = '0;
        sec_word = 16'h0;
        {fails, tests_run, cycles} = '0;
        t_secured();
        t_lockout();
        t_open();
        finish_test();
    end
endmodule // tb_flash_security_lockout
`default_nettype wire
